// >>> include/bcg_defines.svh
// Battery capacity gauge constants: offsets, reset values, timing figures
`ifndef BCG_DEFINES_SVH
`define BCG_DEFINES_SVH

// Clock and time base
`define BCG_CLK_MHZ        100
`define BCG_TICK_US        1000
`define BCG_TICK_CYC       (`BCG_TICK_US * `BCG_CLK_MHZ)
`define BCG_EDV_HOLD_MS    500
`define BCG_EDV_HOLD_CYC   (`BCG_EDV_HOLD_MS * 1000 * `BCG_CLK_MHZ)
`define BCG_SD_TICKS       1000

// Register offsets
`define BCG_A_TEMP         8'h01
`define BCG_A_VSB_LO       8'h02
`define BCG_A_VSB_HI       8'h03
`define BCG_A_NAC_LO       8'h04
`define BCG_A_NAC_HI       8'h05
`define BCG_A_DCR_LO       8'h06
`define BCG_A_DCR_HI       8'h07
`define BCG_A_LMD_LO       8'h08
`define BCG_A_LMD_HI       8'h09
`define BCG_A_FLAGS        8'h0a
`define BCG_A_FIRST_EMPTY_THRESHOLD_THR     8'h0b
`define BCG_A_FINAL_EMPTY_THRESHOLD_THR     8'h0c
`define BCG_A_REL          8'h0d
`define BCG_A_RESET        8'h39

// Values
`define BCG_RESET_KEY      8'h80
`define BCG_FIRST_EMPTY_THRESHOLD_RST       8'h96
`define BCG_FINAL_EMPTY_THRESHOLD_RST       8'h93
`define BCG_THR_MV_STEP    16'h000a
`define BCG_VALID_CHG      10'h100
`define BCG_DCR_MAX        16'hffff
`define BCG_WT_UNITY       5'h10
`define BCG_TEMP_ZERO_CODE 4'h4
`define BCG_TEMP_MAX_CODE  4'hc
`define BCG_REL_STEPS      5

`endif

// >>> include/bcg_pkg.sv
// Battery capacity gauge shared types
package bcg_pkg;
  typedef logic [3:0] bcg_tcode_t;
  typedef logic [4:0] bcg_wt_t;
  typedef logic [2:0][4:0] bcg_wts_t;
  typedef enum logic [2:0] {
    LRN_IDLE  = 3'b001,
    LRN_FULL  = 3'b010,
    LRN_EMPTY = 3'b100
  } bcg_lrn_e;
endpackage : bcg_pkg

// >>> include/bcg_comp_if.sv
// Temperature step and count weights passed from compensation to core
`timescale 1ns/10ps
interface bcg_comp_if;
  bcg_pkg::bcg_tcode_t tcode;
  bcg_pkg::bcg_wts_t   wt;
  modport prov (output tcode, output wt);
  modport user (input tcode, input wt);
endinterface : bcg_comp_if

// >>> core/bcg_comp.sv
// Temperature quantiser and count compensation weights
`timescale 1ns/10ps
`include "bcg_defines.svh"
module bcg_comp (
  input  logic              clk,
  input  logic              rst,
  input  logic signed [7:0] temp_raw,
  input  logic [1:0]        rate_code,
  bcg_comp_if.prov          cmp
);
  import bcg_pkg::*;

  // Ten degree steps, lowest below -30, top from 80 up
  function automatic bcg_tcode_t quantise(input logic signed [7:0] t);
    logic signed [8:0] s;
    s = 9'(t) + 9'sd40;
    if (t < -8'sd30) begin
      quantise = 4'h0;
    end else if (t >= 8'sd80) begin
      quantise = `BCG_TEMP_MAX_CODE;
    end else begin
      quantise = 4'(s / 9'sd10);
    end
  endfunction : quantise

  bcg_tcode_t tq;
  logic       cold;
  assign tq   = quantise(temp_raw);
  assign cold = (tq < `BCG_TEMP_ZERO_CODE);

  // Step registered so learning, display and reads see one stable code per cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp.tcode <= 4'h6;
    end else begin
      cmp.tcode <= tq;
    end
  end

  // Charge and discharge weighed by temperature and rate, self-discharge by temperature only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp.wt <= {3{`BCG_WT_UNITY}};
    end else begin
      cmp.wt[0] <= `BCG_WT_UNITY - (cold ? 5'h04 : 5'h00) - 5'(rate_code);
      cmp.wt[1] <= `BCG_WT_UNITY + (cold ? 5'h04 : 5'h00) + 5'({rate_code, 1'b0});
      cmp.wt[2] <= (tq <= 4'h6) ? 5'h08 : (tq <= 4'h8) ? `BCG_WT_UNITY : 5'h18;
    end
  end
endmodule : bcg_comp

// >>> core/bcg_core.sv
// Battery capacity gauge core: capacity counters, learning, empty flags, registers
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Charge raises count; discharges lower it, raise tally
// - Learn tally only after uninterrupted full-to-empty discharge
// - Initialisation loads learned capacity with programmed full
// - Before learning, count capped at programmed full
// - Transfer only for qualified discharge below first threshold
// - Relative display uses learned capacity as full
// - Charge/discharge: temperature and rate; self-discharge: temperature
// - Empty flags latch until next valid charge
// - Empty checks paused above 2C, resume after 0.5s
// - Host reads cell sense voltage
// - Writing 0x80 to reset_command resets gauge
// - Temperature code upper digit 0 to C
// - Temperature step steers compensation, self-discharge, display
// - Two programmable empty thresholds, final default 1.47V
// - Valid charge after more than 256 counts
// - Count stops rising at learned capacity
// - Discharge tally saturates at FFFFh
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "bcg_defines.svh"
module bcg_core #(
  parameter int TICK_CYCLES     = `BCG_TICK_CYC,
  parameter int EDV_HOLD_CYCLES = `BCG_EDV_HOLD_CYC,
  parameter int SD_TICKS        = `BCG_SD_TICKS
) (
  input  logic              clk,
  input  logic              rst,
  input  logic [7:0]        reg_addr,
  input  logic [7:0]        reg_wdata,
  input  logic              reg_wr,
  input  logic              reg_rd,
  output logic [7:0]        reg_rdata,
  output logic              reg_rvalid,
  input  logic              chg_evt,
  input  logic              dsg_evt,
  input  logic              charge_active,
  input  logic              high_rate,
  input  logic [1:0]        rate_code,
  input  logic signed [7:0] temp_raw,
  input  logic [15:0]       cell_sense_voltage,
  input  logic [15:0]       programmed_full_capacity,
  input  logic              backup_supply_lost,
  output logic [7:0]        temperature_code,
  output logic              first_empty_flag,
  output logic              final_empty_flag,
  output logic [2:0]        rel_level
);
  import bcg_pkg::*;

  bcg_comp_if cmp ();

  bcg_comp u_comp (
    .clk       (clk),
    .rst       (rst),
    .temp_raw  (temp_raw),
    .rate_code (rate_code),
    .cmp       (cmp.prov)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] nominal_capacity_count;
  logic [15:0] discharge_tally;
  logic [15:0] learned_capacity;
  logic        learned_reg;
  logic [7:0]  first_empty_threshold;
  logic [7:0]  final_empty_threshold;
  logic        init_reg;
  logic [31:0] tick_cnt;
  logic        tick;
  logic [31:0] hold_cnt;
  logic        edv_en;
  logic [31:0] sd_cnt;
  logic        sd_evt;
  logic [9:0]  run_reg;
  logic        valid_reg;
  logic        vchg;
  bcg_lrn_e    lrn_reg;
  logic [2:0]  ev;
  logic [2:0][7:0] pend;
  logic [15:0] nac_next;
  logic [15:0] dcr_next;
  logic [9:0]  run_next;
  logic [2:0]  lvl;

  //////////////////////////////////////////////////////////////////////////////
  // Soft reset: held one cycle after reset, the reset key, or backup loss
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= backup_supply_lost ||
                  (reg_wr && reg_addr == `BCG_A_RESET && reg_wdata == `BCG_RESET_KEY);
    end
  end

  // Shared time base; all counters but the empty-check hold and the per-event accumulators step only on its tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'd1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  // Self-discharge estimate, one event per SD_TICKS while charge remains
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sd_cnt <= '0;
    end else if (tick) begin
      sd_cnt <= (sd_cnt == 32'(SD_TICKS - 1)) ? 32'd0 : sd_cnt + 32'd1;
    end
  end
  assign sd_evt = tick && (sd_cnt == 32'(SD_TICKS - 1)) && (nominal_capacity_count != 16'h0000);
  assign ev     = {sd_evt, dsg_evt, chg_evt};

  //////////////////////////////////////////////////////////////////////////////
  // Weighted fractional accumulators, one per count source; whole counts wait
  // for the tick so a burst between ticks is applied in one step
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_acc
      logic [3:0] frac;
      logic [5:0] sum;
      logic [7:0] base;
      assign sum  = {2'b00, frac} + {1'b0, cmp.wt[g]};
      assign base = tick ? 8'h00 : pend[g];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          frac    <= 4'h0;
          pend[g] <= 8'h00;
        end else if (init_reg) begin
          frac    <= 4'h0;
          pend[g] <= 8'h00;
        end else begin
          if (ev[g]) begin
            frac <= sum[3:0];
          end
          // New counts arriving on the tick are kept, not lost
          if (ev[g]) begin
            pend[g] <= (base > 8'hfd) ? 8'hff : base + {6'h00, sum[5:4]};
          end else begin
            pend[g] <= base;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Next count values on a tick
  always_comb begin
    logic signed [18:0] s;
    logic [17:0]        d;
    s = $signed({3'b000, nominal_capacity_count}) + $signed({11'h000, pend[0]})
        - $signed({11'h000, pend[1]}) - $signed({11'h000, pend[2]});
    if (s < 0) begin
      nac_next = 16'h0000;
    end else if (s > $signed({3'b000, learned_capacity})) begin
      nac_next = learned_capacity;
    end else begin
      nac_next = s[15:0];
    end
    d = {2'b00, discharge_tally} + {10'h000, pend[1]}
        + ((nominal_capacity_count != 16'h0000) ? {10'h000, pend[2]} : 18'h00000);
    dcr_next = (d > {2'b00, `BCG_DCR_MAX}) ? `BCG_DCR_MAX : d[15:0];
    // Run stops growing well short of the top, so a full pending step cannot wrap it
    run_next = charge_active ? ((run_reg > 10'h300) ? run_reg : run_reg + {2'b00, pend[0]}) : 10'h000;
  end

  // Valid charge: sustained activity past the count threshold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_reg   <= '0;
      valid_reg <= 1'b0;
    end else if (init_reg || !charge_active) begin
      run_reg   <= '0;
      valid_reg <= 1'b0;
    end else if (tick) begin
      run_reg   <= run_next;
      valid_reg <= valid_reg || (run_next > `BCG_VALID_CHG);
    end
  end
  assign vchg = tick && charge_active && !valid_reg && (run_next > `BCG_VALID_CHG);

  // Nominal capacity count; cleared by the first valid charge after empty
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nominal_capacity_count <= '0;
    end else if (init_reg) begin
      nominal_capacity_count <= '0;
    end else if (vchg && lrn_reg == LRN_EMPTY) begin
      nominal_capacity_count <= '0;
    end else if (tick) begin
      nominal_capacity_count <= nac_next;
    end
  end

  // Discharge tally, restarted when the battery reads full
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      discharge_tally <= '0;
    end else if (init_reg) begin
      discharge_tally <= '0;
    end else if (tick) begin
      discharge_tally <= (nac_next == learned_capacity) ? 16'h0000 : dcr_next;
    end
  end

  // Learning cycle: full, then empty without a valid charge in between
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lrn_reg <= LRN_IDLE;
    end else if (init_reg || vchg) begin
      lrn_reg <= LRN_IDLE;
    end else begin
      case (lrn_reg)
        LRN_IDLE: begin
          if (tick && nac_next == learned_capacity) begin
            lrn_reg <= LRN_FULL;
          end
        end
        LRN_FULL: begin
          if (first_empty_flag) begin
            // Cold end of discharge disqualifies learning
            lrn_reg <= (cmp.tcode >= `BCG_TEMP_ZERO_CODE) ? LRN_EMPTY : LRN_IDLE;
          end
        end
        LRN_EMPTY: begin
          lrn_reg <= LRN_EMPTY;
        end
        default: begin
          lrn_reg <= LRN_IDLE;
        end
      endcase
    end
  end

  // Learned capacity: programmed full on init, tally after a qualified discharge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      learned_capacity <= '0;
      learned_reg      <= 1'b0;
    end else if (init_reg) begin
      learned_capacity <= programmed_full_capacity;
      learned_reg      <= 1'b0;
    end else if (vchg && lrn_reg == LRN_EMPTY && discharge_tally != 16'h0000) begin
      learned_capacity <= discharge_tally;
      learned_reg      <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Empty check hold-off after high discharge rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= '0;
    end else if (high_rate) begin
      hold_cnt <= 32'(EDV_HOLD_CYCLES);
    end else if (hold_cnt != 32'd0) begin
      hold_cnt <= hold_cnt - 32'd1;
    end
  end
  assign edv_en = !high_rate && (hold_cnt == 32'd0);

  // Latched empty flags; a new crossing wins over the valid-charge clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_empty_flag <= 1'b0;
      final_empty_flag <= 1'b0;
    end else if (init_reg) begin
      first_empty_flag <= 1'b0;
      final_empty_flag <= 1'b0;
    end else begin
      first_empty_flag <= (edv_en && cell_sense_voltage < 16'(first_empty_threshold * `BCG_THR_MV_STEP))
                          || (first_empty_flag && !vchg);
      final_empty_flag <= (edv_en && cell_sense_voltage < 16'(final_empty_threshold * `BCG_THR_MV_STEP))
                          || (final_empty_flag && !vchg);
    end
  end

  // Threshold registers in 10 mV per cell
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_empty_threshold <= `BCG_FIRST_EMPTY_THRESHOLD_RST;
      final_empty_threshold <= `BCG_FINAL_EMPTY_THRESHOLD_RST;
    end else if (reg_wr && reg_addr == `BCG_A_FIRST_EMPTY_THRESHOLD_THR) begin
      first_empty_threshold <= reg_wdata;
    end else if (reg_wr && reg_addr == `BCG_A_FINAL_EMPTY_THRESHOLD_THR) begin
      final_empty_threshold <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Relative level in fifths of learned capacity; cold derates the shown charge
  always_comb begin
    logic [15:0] shown;
    logic [18:0] lhs;
    shown = (cmp.tcode < `BCG_TEMP_ZERO_CODE) ?
            nominal_capacity_count - {3'b000, nominal_capacity_count[15:3]} : nominal_capacity_count;
    lhs   = 19'(shown) * 19'(`BCG_REL_STEPS);
    lvl   = 3'd0;
    for (int k = 1; k <= `BCG_REL_STEPS; k++) begin
      if (learned_capacity != 16'h0000 && lhs >= 19'(learned_capacity) * 19'(k)) begin
        lvl = 3'(k);
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rel_level        <= '0;
      temperature_code <= '0;
    end else begin
      rel_level        <= lvl;
      temperature_code <= {cmp.tcode, 4'h0};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register reads: data one cycle after the strobe, unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `BCG_A_TEMP:     reg_rdata <= {cmp.tcode, 4'h0};
          `BCG_A_VSB_LO:   reg_rdata <= cell_sense_voltage[7:0];
          `BCG_A_VSB_HI:   reg_rdata <= cell_sense_voltage[15:8];
          `BCG_A_NAC_LO:   reg_rdata <= nominal_capacity_count[7:0];
          `BCG_A_NAC_HI:   reg_rdata <= nominal_capacity_count[15:8];
          `BCG_A_DCR_LO:   reg_rdata <= discharge_tally[7:0];
          `BCG_A_DCR_HI:   reg_rdata <= discharge_tally[15:8];
          `BCG_A_LMD_LO:   reg_rdata <= learned_capacity[7:0];
          `BCG_A_LMD_HI:   reg_rdata <= learned_capacity[15:8];
          `BCG_A_FLAGS:    reg_rdata <= {3'b000, valid_reg, lrn_reg != LRN_IDLE, learned_reg,
                                         final_empty_flag, first_empty_flag};
          `BCG_A_FIRST_EMPTY_THRESHOLD_THR: reg_rdata <= first_empty_threshold;
          `BCG_A_FINAL_EMPTY_THRESHOLD_THR: reg_rdata <= final_empty_threshold;
          `BCG_A_REL:      reg_rdata <= {5'b00000, lvl};
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : bcg_core

// >>> tb/bcg_core_sva.sv
// Assertion checker bound to the battery capacity gauge core
`timescale 1ns/10ps
module bcg_core_chk (
  input logic              clk,
  input logic              rst,
  input logic [7:0]        reg_addr,
  input logic [7:0]        reg_wdata,
  input logic              reg_wr,
  input logic              reg_rd,
  input logic [7:0]        reg_rdata,
  input logic              reg_rvalid,
  input logic              charge_active,
  input logic              high_rate,
  input logic signed [7:0] temp_raw,
  input logic [15:0]       cell_sense_voltage,
  input logic              backup_supply_lost,
  input logic [7:0]        temperature_code,
  input logic              first_empty_flag,
  input logic              final_empty_flag,
  input logic [2:0]        rel_level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Expected step of a raw reading, worked out here and not borrowed
  function automatic logic [3:0] step_of(input logic signed [7:0] t);
    if (t < -30) return 4'h0;
    if (t >= 80) return 4'hc;
    return 4'((int'(t) + 40) / 10);
  endfunction : step_of

  //////////////////////////////////////////////////////////////////////////////
  // Steps shared by the properties
  sequence s_rd_vsb; reg_rd && reg_addr == 8'h02 && $stable(cell_sense_voltage); endsequence
  sequence s_init; (reg_wr && reg_addr == 8'h39 && reg_wdata == 8'h80) || backup_supply_lost; endsequence
  // Nothing that may clear a flag, now or one cycle back
  sequence s_quiet;
    !charge_active && !$past(charge_active) && !reg_wr && !$past(reg_wr) && !backup_supply_lost &&
    !$past(backup_supply_lost);
  endsequence
  sequence s_rate_drop; high_rate ##1 high_rate && !first_empty_flag && !final_empty_flag ##1 !high_rate; endsequence

  //////////////////////////////////////////////////////////////////////////////
  property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer mistimed");
  property p_vsb; s_rd_vsb |=> reg_rdata == $past(cell_sense_voltage[7:0]); endproperty
  a_vsb: assert property (p_vsb) else $error("sense voltage read wrong");
  property p_unmapped;
    reg_rd && (reg_addr == 8'h00 || reg_addr inside {[8'h0e:8'h38], [8'h3a:8'hff]}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_temp_form; temperature_code[3:0] == 4'h0 && temperature_code[7:4] <= 4'hc; endproperty
  a_temp_form: assert property (p_temp_form) else $error("temperature code out of form");
  property p_temp_step; $stable(temp_raw) [*5] |-> temperature_code[7:4] == step_of(temp_raw); endproperty
  a_temp_step: assert property (p_temp_step) else $error("temperature step wrong");
  property p_first_hold; first_empty_flag ##0 s_quiet |=> first_empty_flag; endproperty
  a_first_hold: assert property (p_first_hold) else $error("first flag dropped");
  property p_final_hold; final_empty_flag ##0 s_quiet |=> final_empty_flag; endproperty
  a_final_hold: assert property (p_final_hold) else $error("final flag dropped");
  // The hold after a fast discharge must keep both flags down for a while
  property p_edv_pause; s_rate_drop |=> (!first_empty_flag && !final_empty_flag) [*3]; endproperty
  a_edv_pause: assert property (p_edv_pause) else $error("flag set inside hold");
  property p_rate_gate; $rose(first_empty_flag) |-> !$past(high_rate); endproperty
  a_rate_gate: assert property (p_rate_gate) else $error("flag set at high rate");
  property p_init_clear;
    s_init ##0 (cell_sense_voltage > 16'h0a00) [*3] |=> !first_empty_flag && !final_empty_flag;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("init left a flag");
  property p_rel_range; rel_level <= 3'h5; endproperty
  a_rel_range: assert property (p_rel_range) else $error("display level above full");
endmodule : bcg_core_chk

bind bcg_core bcg_core_chk bcg_core_chk_inst (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .charge_active(charge_active), .high_rate(high_rate),
  .temp_raw(temp_raw), .cell_sense_voltage(cell_sense_voltage), .backup_supply_lost(backup_supply_lost),
  .temperature_code(temperature_code), .first_empty_flag(first_empty_flag),
  .final_empty_flag(final_empty_flag), .rel_level(rel_level));

// >>> tb/bcg_host_model.sv
// Host processor model issuing register reads and writes
`timescale 1ns/10ps
module bcg_host_model (
  input  logic       clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd
);
  // Idle from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One strobe cycle per access; idle lines show the inverse so stale values never look valid
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    reg_wr    = wr;
    reg_rd    = !wr;
    reg_addr  = addr;
    reg_wdata = data;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask : access
endmodule : bcg_host_model

// >>> tb/test_battery_capacity_gauge_core.sv
// Self-checking bench for the battery capacity gauge core
`timescale 1ns/10ps
module test_battery_capacity_gauge_core;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, temperature_code;
  logic              reg_wr, reg_rd, reg_rvalid, chg_evt, dsg_evt, charge_active, high_rate;
  logic              backup_supply_lost, first_empty_flag, final_empty_flag;
  logic [1:0]        rate_code;
  logic [2:0]        rel_level;
  logic signed [7:0] temp_raw;
  logic [15:0]       cell_sense_voltage, programmed_full_capacity, d;
  logic [15:0]       exp_q[$];
  logic signed [7:0] tv[14] = '{-128, -31, -30, -21, -1, 0, 9, 10, 25, 79, 80, 127, 0, 0};
  int                fails = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  // Short tick and hold; self-discharge pushed out of reach so counts stay exact
  bcg_core #(.TICK_CYCLES(4), .EDV_HOLD_CYCLES(8), .SD_TICKS(32'h3fff_ffff)) bcg_core_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chg_evt(chg_evt), .dsg_evt(dsg_evt),
    .charge_active(charge_active), .high_rate(high_rate), .rate_code(rate_code), .temp_raw(temp_raw),
    .cell_sense_voltage(cell_sense_voltage), .programmed_full_capacity(programmed_full_capacity),
    .backup_supply_lost(backup_supply_lost), .temperature_code(temperature_code),
    .first_empty_flag(first_empty_flag), .final_empty_flag(final_empty_flag), .rel_level(rel_level));
  bcg_host_model bcg_host_model_inst (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // 100 MHz clock
  always #5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] step_of(input logic signed [7:0] t);
    if (t < -30) return 4'h0;
    if (t >= 80) return 4'hc;
    return 4'((int'(t) + 40) / 10);
  endfunction : step_of

  task automatic finish_test();
    // A read whose answer never came is a mismatch too
    if (exp_q.size() != 0) begin
      fails++;
    end
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // Masked byte compare against the oldest note
  task automatic cmp_rd(input logic [15:0] note);
    cmp_count++;
    if ((reg_rdata & note[15:8]) !== (note[7:0] & note[15:8])) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, reg_rdata, note[7:0]);
    end
  endtask : cmp_rd

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    bcg_host_model_inst.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic rd16(input logic [7:0] a, input logic [15:0] v);
    rd(a, v[7:0], 8'hff);
    rd(a + 8'h01, v[15:8], 8'hff);
  endtask : rd16

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // One count per cycle for n cycles, then three ticks to let pending counts land
  task automatic ev(input logic chg, input int n);
    chg_evt       = chg;
    dsg_evt       = !chg;
    charge_active = chg;
    wait_cyc(n);
    chg_evt       = 1'b0;
    dsg_evt       = 1'b0;
    charge_active = 1'b0;
    wait_cyc(12);
  endtask : ev

  //////////////////////////////////////////////////////////////////////////////
  // Answers are taken at the falling edge, once they have settled
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("wrong value at %0t: got %h expected %h", $time, reg_rdata, 8'h00);
      end else begin
        cmp_rd(exp_q.pop_front());
      end
    end
  end

  // Hang guard; the whole sequence needs some 54600 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    chg_evt = 1'b0;
    dsg_evt = 1'b0;
    charge_active = 1'b0;
    high_rate = 1'b0;
    rate_code = 2'h0;
    temp_raw = 8'sd25;
    backup_supply_lost = 1'b0;
    void'($urandom(60));
    programmed_full_capacity = 16'h02bc + 16'($urandom % 64);
    d = 16'h012c + 16'($urandom % 50);
    cell_sense_voltage = 16'h0bb8 + 16'($urandom % 256);
    tv[12] = 8'($urandom);
    tv[13] = 8'($urandom);
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    wait_cyc(2);
    rd(8'h0b, 8'h96, 8'hff);
    rd(8'h0c, 8'h93, 8'hff);
    rd16(8'h08, programmed_full_capacity);
    rd16(8'h02, cell_sense_voltage);
    rd(8'h20, 8'h00, 8'hff);
    // Overcharge: the count must stop at the programmed full value
    ev(1'b1, 2000);
    rd16(8'h04, programmed_full_capacity);
    rd16(8'h06, 16'h0000);
    rd(8'h0d, 8'h05, 8'hff);
    ev(1'b0, int'(d));
    rd16(8'h04, programmed_full_capacity - d);
    rd16(8'h06, d);
    // 1.499 V sits between the two thresholds: first flag only, and it stays
    cell_sense_voltage = 16'h05db;
    wait_cyc(16);
    rd(8'h0a, 8'h01, 8'h03);
    cell_sense_voltage = 16'h0bb8;
    wait_cyc(4);
    rd(8'h0a, 8'h01, 8'h03);
    // Valid charge after a clean full-to-empty run learns the tally
    ev(1'b1, 2000);
    rd(8'h0a, 8'h00, 8'h03);
    rd16(8'h08, d);
    rd16(8'h04, d);
    rd(8'h0d, 8'h05, 8'hff);
    // Cold shows seven eighths of the count, one fifth short of full
    temp_raw = -8'sd5;
    wait_cyc(4);
    rd(8'h0d, 8'h04, 8'hff);
    temp_raw = 8'sd25;
    backup_supply_lost = 1'b1;
    wait_cyc(1);
    backup_supply_lost = 1'b0;
    wait_cyc(4);
    rd16(8'h08, programmed_full_capacity);
    rd16(8'h04, 16'h0000);
    rd(8'h0d, 8'h00, 8'hff);
    // Fast discharge holds off both flags until the hold has run out
    high_rate = 1'b1;
    cell_sense_voltage = 16'h05bd;
    wait_cyc(20);
    rd(8'h0a, 8'h00, 8'h03);
    high_rate = 1'b0;
    rd(8'h0a, 8'h00, 8'h03);
    wait_cyc(12);
    rd(8'h0a, 8'h03, 8'h03);
    // Only the key value resets the gauge
    cell_sense_voltage = 16'h0bb8;
    bcg_host_model_inst.access(1'b1, 8'h39, 8'h55);
    rd(8'h0a, 8'h03, 8'h03);
    bcg_host_model_inst.access(1'b1, 8'h39, 8'h80);
    wait_cyc(2);
    rd(8'h0a, 8'h00, 8'h03);
    foreach (tv[i]) begin
      temp_raw = tv[i];
      wait_cyc(4);
      rd(8'h01, {step_of(tv[i]), 4'h0}, 8'hff);
    end
    // Highest rate weight drives the tally past its ceiling
    temp_raw = 8'sd25;
    rate_code = 2'h3;
    ev(1'b0, 50000);
    rd16(8'h06, 16'hffff);
    bcg_host_model_inst.access(1'b1, 8'h0c, 8'h90);
    rd(8'h0c, 8'h90, 8'hff);
    wait_cyc(4);
    finish_test();
  end
endmodule : test_battery_capacity_gauge_core
